// File: logic/cohb_pkg.sv
// constants for the tolerance judgment and batch input block
// assumes a 20 MHz ref_clk and a simple strobe register port
package cohb_pkg;
	// ************************************************************
	// widths and sizes
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam int VAL_W = 32;
	localparam int HYS_W = 21;
	localparam int EXP_N = 4;
	localparam int CMD_W = 5;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HYST = 8'h04;
	localparam logic [7:0] OFS_HIGH = 8'h08;
	localparam logic [7:0] OFS_LOW = 8'h0c;
	localparam logic [7:0] OFS_OHIGH = 8'h10;
	localparam logic [7:0] OFS_OLOW = 8'h14;
	localparam logic [7:0] OFS_TRIG = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1c;
	localparam logic [7:0] OFS_PV = 8'h20;
	localparam logic [7:0] OFS_DISP = 8'h24;
	// ************************************************************
	// control fields
	// ************************************************************
	localparam int CTRL_NC_BIT = 0;
	localparam int CTRL_RES_LSB = 1;
	localparam int CTRL_BATCH_BIT = 3;
	// ************************************************************
	// reset values, values in 0.0001 mm units
	// ************************************************************
	localparam logic [1:0] RES_RST = 2'h0;
	localparam logic [HYS_W-1:0] HYS_RST = 21'h00_001e;
	localparam logic [HYS_W-1:0] HYS_MAX = 21'h1e_847f;
	localparam logic [VAL_W-1:0] HIGH_RST = 32'h0000_0064;
	localparam logic [VAL_W-1:0] LOW_RST = 32'hffff_ff9c;
	localparam logic [VAL_W-1:0] OHIGH_RST = 32'h0000_00c8;
	localparam logic [VAL_W-1:0] OLOW_RST = 32'hffff_ff38;
	localparam logic [VAL_W-1:0] TRIG_RST = 32'h0000_0000;
	// ************************************************************
	// display steps in 0.0001 mm units
	// ************************************************************
	localparam logic signed [VAL_W-1:0] STEP_0 = 32'sh0000_0001;
	localparam logic signed [VAL_W-1:0] STEP_1 = 32'sh0000_000a;
	localparam logic signed [VAL_W-1:0] STEP_2 = 32'sh0000_0064;
	localparam logic signed [VAL_W-1:0] STEP_3 = 32'sh0000_03e8;
	// input command bit positions
	localparam int CMD_TIMING = 0;
	localparam int CMD_PRESET = 1;
	localparam int CMD_RESET = 2;
	localparam int CMD_BANK_A = 3;
	localparam int CMD_BANK_B = 4;
endpackage

// File: logic/cohb_judge.sv
// tolerance judgment with hysteresis, output polarity, display rounding
// and batch forwarding of external inputs to expansion units
// assumes present_value comes from logic on ref_clk; pins are async
//
// Operation
// (R1) normally open is default: outputs active when criterion met.
// (R2) normally closed inverts every tolerance output; here trigger_out is left uninverted.
// (R3) display resolution has four steps, finest at reset.
// (R4) resolution shapes displayed values only; judgment uses full value.
// (R5) one hysteresis amount serves all four thresholds and trigger level.
// (R6) spindle limit outputs use no hysteresis.
// (R7) assert and release points differ by the hysteresis amount.
// (R8) hysteresis programmable over full range, three micrometres at reset.
// (R9) zero hysteresis gives direct comparison with no band.
// (R10) batch mode forwards timing, preset, reset, bank a and b inputs.
// (R11) in batch mode each main input event acts in every expansion unit.
// (R12) in batch mode expansion units' own input lines are ignored.
// (R13) batch selection only takes effect with an expansion unit attached.
// (R14) by default every unit follows only its own input lines.
// (R15) controller keeps longer minimum input pulses in batch mode; here no pulse width is enforced in either mode.
// (R16) outer high sits above high, outer low below low.
// (R17) upper asserts above threshold, releases at threshold minus hysteresis.
// (R18) pass is active exactly when neither high nor low judgment is.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cohb_judge
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// register port
	input wire logic [cohb_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// measurement
	input wire logic signed [cohb_pkg::VAL_W-1:0] present_value,
	output logic signed [cohb_pkg::VAL_W-1:0] display_value,
	// tolerance outputs
	output logic high_out,
	output logic pass_out,
	output logic low_out,
	output logic outer_high_out,
	output logic outer_low_out,
	output logic trigger_out,
	// spindle limit pins and outputs
	input wire logic limit_extend_pin,
	input wire logic limit_retract_pin,
	output logic limit_extend_out,
	output logic limit_retract_out,
	// external inputs and expansion units
	input wire logic [cohb_pkg::CMD_W-1:0] main_in_pin,
	input wire logic [cohb_pkg::EXP_N*cohb_pkg::CMD_W-1:0] exp_in_pin,
	input wire logic [cohb_pkg::EXP_N-1:0] exp_attached_pin,
	output logic [cohb_pkg::CMD_W-1:0] main_cmd,
	output logic [cohb_pkg::EXP_N*cohb_pkg::CMD_W-1:0] exp_cmd
);
	import cohb_pkg::*;
	localparam int PW = EXP_N * CMD_W + EXP_N + CMD_W + 2;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [PW-1:0] pin_meta;
	logic [PW-1:0] pin_sync;
	logic [PW-1:0] pin_raw;
	logic [CMD_W-1:0] main_s;
	logic [EXP_N*CMD_W-1:0] exp_s;
	logic [EXP_N-1:0] att_s;
	logic lim_ext_s;
	logic lim_ret_s;

	// two flops per pin, only the second is read
	assign pin_raw = {exp_in_pin, exp_attached_pin, main_in_pin,
		limit_extend_pin, limit_retract_pin};
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end
	assign {exp_s, att_s, main_s, lim_ext_s, lim_ret_s} = pin_sync;

	// ************************************************************
	// registers
	// ************************************************************
	logic nc_mode, next_nc_mode;
	logic [1:0] res_sel, next_res_sel;
	logic batch_en, next_batch_en;
	logic [HYS_W-1:0] hys, next_hys;
	logic signed [VAL_W-1:0] th_high, next_th_high;
	logic signed [VAL_W-1:0] th_low, next_th_low;
	logic signed [VAL_W-1:0] th_ohigh, next_th_ohigh;
	logic signed [VAL_W-1:0] th_olow, next_th_olow;
	logic signed [VAL_W-1:0] th_trig, next_th_trig;
	logic [31:0] next_reg_rdata;
	logic j_high, j_low, j_ohigh, j_olow, j_trig;
	logic j_pass;

	// register writes and read mux
	always_comb
	begin
		next_nc_mode = nc_mode;
		next_res_sel = res_sel;
		next_batch_en = batch_en;
		next_hys = hys;
		next_th_high = th_high;
		next_th_low = th_low;
		next_th_ohigh = th_ohigh;
		next_th_olow = th_olow;
		next_th_trig = th_trig;
		next_reg_rdata = 32'h0000_0000;
		if (reg_wr)
		begin
			unique case (reg_addr)
				OFS_CTRL:
				begin
					next_nc_mode = reg_wdata[CTRL_NC_BIT]; // R1 R2
					next_res_sel = reg_wdata[CTRL_RES_LSB +: 2]; // R3
					next_batch_en = reg_wdata[CTRL_BATCH_BIT];
				end
				OFS_HYST:
				begin
					// clamp to top of range
					if (reg_wdata[HYS_W-1:0] > HYS_MAX || |reg_wdata[31:HYS_W])
						next_hys = HYS_MAX; // R8
					else
						next_hys = reg_wdata[HYS_W-1:0]; // R8
				end
				OFS_HIGH: next_th_high = reg_wdata;
				OFS_LOW: next_th_low = reg_wdata;
				OFS_OHIGH: next_th_ohigh = reg_wdata; // R16
				OFS_OLOW: next_th_olow = reg_wdata; // R16
				OFS_TRIG: next_th_trig = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				OFS_CTRL: next_reg_rdata = {28'h000_0000, batch_en,
					res_sel, nc_mode};
				OFS_HYST: next_reg_rdata = {11'h000, hys};
				OFS_HIGH: next_reg_rdata = th_high;
				OFS_LOW: next_reg_rdata = th_low;
				OFS_OHIGH: next_reg_rdata = th_ohigh;
				OFS_OLOW: next_reg_rdata = th_olow;
				OFS_TRIG: next_reg_rdata = th_trig;
				OFS_STAT: next_reg_rdata = {24'h00_0000, lim_ext_s,
					lim_ret_s, j_trig, j_olow, j_ohigh, j_low, j_pass,
					j_high};
				OFS_PV: next_reg_rdata = present_value;
				OFS_DISP: next_reg_rdata = display_value;
				default: next_reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	// register storage
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			nc_mode <= 1'b0; // R1
			res_sel <= RES_RST; // R3
			batch_en <= 1'b0; // R14
			hys <= HYS_RST; // R8
			th_high <= HIGH_RST;
			th_low <= LOW_RST;
			th_ohigh <= OHIGH_RST;
			th_olow <= OLOW_RST;
			th_trig <= TRIG_RST;
			reg_rdata <= 32'h0000_0000;
		end
		else
		begin
			nc_mode <= next_nc_mode;
			res_sel <= next_res_sel;
			batch_en <= next_batch_en;
			hys <= next_hys;
			th_high <= next_th_high;
			th_low <= next_th_low;
			th_ohigh <= next_th_ohigh;
			th_olow <= next_th_olow;
			th_trig <= next_th_trig;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ************************************************************
	// judgment with hysteresis
	// ************************************************************
	logic signed [VAL_W+1:0] pv_x, hys_x;
	logic signed [VAL_W+1:0] hi_x, lo_x, oh_x, ol_x, tr_x;
	logic next_j_high, next_j_low, next_j_ohigh, next_j_olow, next_j_trig;

	// upper side: set above, clear at or below threshold minus band
	function automatic logic upper(input logic cur,
		input logic signed [VAL_W+1:0] pv, input logic signed [VAL_W+1:0] th,
		input logic signed [VAL_W+1:0] band);
		upper = cur ? (pv > th - band) : (pv > th);
	endfunction

	// lower side: set below, clear at or above threshold plus band
	function automatic logic lower(input logic cur,
		input logic signed [VAL_W+1:0] pv, input logic signed [VAL_W+1:0] th,
		input logic signed [VAL_W+1:0] band);
		lower = cur ? (pv < th + band) : (pv < th);
	endfunction

	// full-resolution value, one shared band; sign-widened so no sum wraps
	assign pv_x = (VAL_W+2)'(present_value); // R4
	assign hys_x = {13'h0000, hys}; // R5
	assign hi_x = (VAL_W+2)'(th_high);
	assign lo_x = (VAL_W+2)'(th_low);
	assign oh_x = (VAL_W+2)'(th_ohigh);
	assign ol_x = (VAL_W+2)'(th_olow);
	assign tr_x = (VAL_W+2)'(th_trig);
	always_comb
	begin
		next_j_high = upper(j_high, pv_x, hi_x, hys_x); // R17 R7 R9
		next_j_ohigh = upper(j_ohigh, pv_x, oh_x, hys_x); // R16
		next_j_trig = upper(j_trig, pv_x, tr_x, hys_x); // R5
		next_j_low = lower(j_low, pv_x, lo_x, hys_x); // R17 R7 R9
		next_j_olow = lower(j_olow, pv_x, ol_x, hys_x); // R16
	end
	assign j_pass = !(j_high || j_low); // R18

	// judgment state
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			{j_high, j_low, j_ohigh, j_olow, j_trig} <= 5'h00;
		end
		else
		begin
			j_high <= next_j_high;
			j_low <= next_j_low;
			j_ohigh <= next_j_ohigh;
			j_olow <= next_j_olow;
			j_trig <= next_j_trig;
		end
	end

	// ************************************************************
	// output polarity, limits and display
	// ************************************************************
	logic signed [VAL_W-1:0] next_display_value;
	logic signed [VAL_W-1:0] step;

	// display rounds toward zero to the chosen step
	always_comb
	begin
		unique case (res_sel)
			2'h0: step = STEP_0;
			2'h1: step = STEP_1;
			2'h2: step = STEP_2;
			2'h3: step = STEP_3;
		endcase
		next_display_value = (present_value / step) * step; // R3 R4
	end

	// polarity applied last, limits pass with no band
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			high_out <= 1'b0;
			pass_out <= 1'b0;
			low_out <= 1'b0;
			outer_high_out <= 1'b0;
			outer_low_out <= 1'b0;
			trigger_out <= 1'b0;
			limit_extend_out <= 1'b0;
			limit_retract_out <= 1'b0;
			display_value <= 32'sh0000_0000;
		end
		else
		begin
			high_out <= j_high ^ nc_mode; // R1 R2
			pass_out <= j_pass ^ nc_mode; // R1 R2
			low_out <= j_low ^ nc_mode; // R1 R2
			outer_high_out <= j_ohigh ^ nc_mode; // R2
			outer_low_out <= j_olow ^ nc_mode; // R2
			trigger_out <= j_trig;
			limit_extend_out <= lim_ext_s; // R6
			limit_retract_out <= lim_ret_s; // R6
			display_value <= next_display_value;
		end
	end

	// ************************************************************
	// input routing to expansion units
	// ************************************************************
	logic batch_act;
	logic [EXP_N*CMD_W-1:0] next_exp_cmd;

	// batch only counts when something is attached
	assign batch_act = batch_en && |att_s; // R13
	for (genvar k = 0; k < EXP_N; k++)
	begin : g_unit
		// one driver per slice, unattached units see nothing
		assign next_exp_cmd[k*CMD_W +: CMD_W] = !att_s[k] ? '0 :
			batch_act ? main_s : exp_s[k*CMD_W +: CMD_W]; // R10 R11 R12 R14
	end

	// routed commands
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			main_cmd <= '0;
			exp_cmd <= '0;
		end
		else
		begin
			main_cmd <= main_s; // R14
			exp_cmd <= next_exp_cmd;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_nc_high;
		nc_mode && j_high && !j_low;
	endsequence
	chk_pass_exclusive: assert property ( // R18
		!srst |=> pass_out == $past(!(j_high || j_low) ^ nc_mode))
		else $error("pass wrong");
	chk_no_polarity: assert property ( // R1
		!nc_mode && j_high |=> high_out)
		else $error("no high not active");
	chk_nc_invert: assert property ( // R2
		s_nc_high |=> !high_out && pass_out && low_out)
		else $error("nc polarity wrong");
	chk_high_assert: assert property ( // R17
		!srst && pv_x > hi_x |=> j_high)
		else $error("high not set");
	chk_high_release: assert property ( // R17
		j_high && pv_x <= hi_x - hys_x |=> !j_high)
		else $error("high not released");
	chk_band_hold: assert property ( // R7
		j_low && pv_x >= lo_x && pv_x < lo_x + hys_x |=> j_low)
		else $error("low band not held");
	chk_zero_band: assert property ( // R9
		hys == '0 && $stable(hys) |=> j_high == $past(pv_x > hi_x))
		else $error("zero band not direct");
	chk_hys_range: assert property ( // R8
		hys <= HYS_MAX)
		else $error("band out of range");
	chk_batch_fwd: assert property ( // R10
		batch_act && att_s[0] |=> exp_cmd[CMD_W-1:0] == $past(main_s)
		##1 main_cmd == $past(main_s))
		else $error("batch not forwarded");
	chk_own_lines: assert property ( // R14
		!batch_act && att_s[0] |=>
		exp_cmd[CMD_W-1:0] == $past(exp_s[CMD_W-1:0]))
		else $error("own lines not used");
	chk_limit_direct: assert property ( // R6
		!srst |=> limit_extend_out == $past(lim_ext_s)
		&& limit_retract_out == $past(lim_ret_s))
		else $error("limit delayed or banded");
	chk_fine_display: assert property ( // R3
		!srst && res_sel == 2'h0 |=> display_value == $past(present_value))
		else $error("fine display rounded");
endmodule
`default_nettype wire

// File: bench/cohb_exp_model.sv
// expansion unit model: own input lines and attach detect lines
// assumes the bench sets att and own_val right after a rising edge
`timescale 1ns/100ps
`default_nettype none
module cohb_exp_model
(
	// settings from the bench
	input wire logic [3:0] att,
	input wire logic [19:0] own_val,
	// lines to the main unit
	output logic [19:0] exp_in_pin,
	output logic [3:0] exp_attached_pin
);
	// a detached unit leaves its lines floating, shown as inverted data
	always_comb
	begin
		exp_attached_pin = att;
		for (int k = 0; k < 4; k++)
			exp_in_pin[5*k +: 5] = att[k] ? own_val[5*k +: 5] : ~own_val[5*k +: 5];
	end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the tolerance judgment and batch input block
// assumes cohb_pkg and cohb_judge are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import cohb_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic signed [31:0] present_value = 32'sh0000_0000;
	logic signed [31:0] display_value;
	logic high_out, pass_out, low_out, outer_high_out, outer_low_out, trigger_out;
	logic limit_extend_pin = 1'b0;
	logic limit_retract_pin = 1'b0;
	logic limit_extend_out, limit_retract_out;
	logic [4:0] main_in_pin = 5'h00;
	logic [19:0] own_val = 20'h0_0000;
	logic [3:0] att = 4'h0;
	logic [19:0] exp_in_pin;
	logic [3:0] exp_attached_pin;
	logic [4:0] main_cmd;
	logic [19:0] exp_cmd;
	logic nc = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] rq[$];
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int pv_tab[8] = '{101, 80, 70, -101, -80, -70, 201, -201};
	logic [4:0] ex_tab[8] = '{5'h01, 5'h01, 5'h02, 5'h04, 5'h04, 5'h02,
		5'h09, 5'h14};
	// clock
	always #25 ref_clk = ~ref_clk;
	// device and far side
	cohb_judge dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .present_value(present_value),
		.display_value(display_value), .high_out(high_out), .pass_out(pass_out),
		.low_out(low_out), .outer_high_out(outer_high_out),
		.outer_low_out(outer_low_out), .trigger_out(trigger_out),
		.limit_extend_pin(limit_extend_pin), .limit_retract_pin(limit_retract_pin),
		.limit_extend_out(limit_extend_out), .limit_retract_out(limit_retract_out),
		.main_in_pin(main_in_pin), .exp_in_pin(exp_in_pin),
		.exp_attached_pin(exp_attached_pin), .main_cmd(main_cmd), .exp_cmd(exp_cmd));
	cohb_exp_model exp_units (.att(att), .own_val(own_val),
		.exp_in_pin(exp_in_pin), .exp_attached_pin(exp_attached_pin));
	// ************************************************************
	// checking and closing
	// ************************************************************
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] expv);
		tests_run++;
		if (seen !== expv)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
		end
	endtask
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// read data compared one cycle after the read strobe
	always @(posedge ref_clk)
	begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1)
			chk("reg_rdata", reg_rdata, rq.pop_front());
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ************************************************************
	// drivers
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] expv);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(expv);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	// bits: outer low, outer high, low, pass, high
	task automatic jud(input logic [31:0] v, input logic [4:0] e);
		present_value <= v;
		repeat (3) @(posedge ref_clk);
		chk("judge", 32'({outer_low_out, outer_high_out, low_out, pass_out,
			high_out}), 32'(e ^ {5{nc}}));
	endtask
	// inputs held five cycles, longer than the sync path
	task automatic bat(input logic [4:0] m, input logic [19:0] own,
		input logic [3:0] a, input logic [19:0] e);
		main_in_pin <= m;
		own_val <= own;
		att <= a;
		repeat (5) @(posedge ref_clk);
		chk("exp_cmd", 32'(exp_cmd), 32'(e));
		chk("main_cmd", 32'(main_cmd), 32'(m));
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		void'($urandom(32'hf338));
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_HYST, 32'h0000_001e);
		rd(OFS_CTRL, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000);
		wr(OFS_HYST, 32'h00ff_ffff);
		rd(OFS_HYST, 32'h001e_847f);
		wr(OFS_HYST, 32'h0000_001e);
		// coarsest display step, judgment keeps full value
		wr(OFS_CTRL, 32'h0000_0006);
		jud(32'h0012_d687, 5'h09);
		chk("display", display_value, 32'h0012_d450);
		chk("trigger", 32'(trigger_out), 32'h0000_0001);
		jud(32'hffff_f831, 5'h14);
		chk("display", display_value, 32'hffff_fc18);
		chk("trigger", 32'(trigger_out), 32'h0000_0000);
		jud(32'h0000_0000, 5'h02);
		for (int i = 0; i < 8; i++)
			jud(32'(pv_tab[i]), ex_tab[i]);
		jud(32'h0000_0000, 5'h02);
		// inverted polarity
		wr(OFS_CTRL, 32'h0000_0001);
		nc = 1'b1;
		jud(32'h0000_0065, 5'h01);
		jud(32'h0000_0046, 5'h02);
		repeat (4)
			jud(32'($urandom_range(100)) - 32'h0000_0032, 5'h02);
		// no band
		wr(OFS_HYST, 32'h0000_0000);
		jud(32'h0000_0065, 5'h01);
		chk("trigger", 32'(trigger_out), 32'h0000_0001);
		jud(32'h0000_0064, 5'h02);
		jud(32'hffff_ff9b, 5'h04);
		chk("trigger", 32'(trigger_out), 32'h0000_0000);
		jud(32'hffff_ff9c, 5'h02);
		// moved high threshold, raw status word before polarity
		wr(OFS_HIGH, 32'h0000_00c8);
		rd(OFS_HIGH, 32'h0000_00c8);
		jud(32'h0000_0065, 5'h02);
		rd(OFS_STAT, 32'h0000_0022);
		// limit outputs follow the pins
		limit_extend_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("limit_ext", 32'(limit_extend_out), 32'h0000_0001);
		limit_extend_pin <= 1'b0;
		limit_retract_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("limit_ext", 32'(limit_extend_out), 32'h0000_0000);
		chk("limit_ret", 32'(limit_retract_out), 32'h0000_0001);
		// individual, then batch input
		bat(5'h0a, 20'h0_0015, 4'h1, 20'h0_0015);
		wr(OFS_CTRL, 32'h0000_0008);
		bat(5'h0a, 20'h0_0015, 4'h1, 20'h0_000a);
		for (int i = 0; i < 5; i++)
			bat(5'(1 << i), 20'hf_ffff, 4'h5,
				{5'h00, 5'(1 << i), 5'h00, 5'(1 << i)});
		bat(5'h0a, 20'h0_0015, 4'h0, 20'h0_0000);
		print_verdict();
	end
endmodule
`default_nettype wire
